// >>> src/sbs_pkg.sv
// Purpose: shared constants and types for the sideband status payload block
// Assumes: one 25 MHz clock, APB register access
// Notes: record bit positions index the 128-bit status record
package sbs_pkg;
  // response framing
  localparam logic [7:0] SBS_BYTE_COUNT = 8'h11;
  localparam logic [7:0] SBS_OPC_LAST = 8'h50;
  localparam logic [7:0] SBS_OPC_FIRST = 8'h90;
  localparam logic [7:0] SBS_OPC_MIDDLE = 8'h10;
  localparam int SBS_REC_BYTES = 16;
  localparam int SBS_FRAME_BYTES = 18;
  localparam int SBS_REC_W = 128;
  // record field positions
  localparam int SBS_REC_LEN_W = 14;
  localparam int SBS_REC_FCS_INS = 25;
  localparam int SBS_REC_XVLAN = 29;
  localparam int SBS_REC_VSTRIP = 30;
  localparam int SBS_REC_DIR = 34;
  localparam int SBS_REC_LAN = 35;
  localparam int SBS_REC_VTAG_LSB = 48;
  localparam int SBS_REC_ERR_LSB = 64;
  localparam int SBS_REC_STAT_LSB = 72;
  localparam int SBS_REC_MNG_LSB = 88;
  localparam int SBS_MNG_W = 40;
  localparam int SBS_MNG_FLEX_MATCH = 27;
  localparam int SBS_MNG_IP_MATCH = 30;
  localparam int SBS_MNG_IP_V6 = 31;
  localparam int SBS_MNG_ARP = 4;
  // register map, byte addresses
  localparam logic [11:0] SBS_OFS_CTRL = 12'h000;
  localparam logic [11:0] SBS_OFS_TMO = 12'h004;
  localparam logic [11:0] SBS_OFS_STAT = 12'h008;
  localparam logic [11:0] SBS_OFS_SENT = 12'h00c;
  localparam logic [11:0] SBS_OFS_DROP = 12'h010;
  localparam int SBS_CTRL_MNG_EN = 0;
  localparam logic [31:0] SBS_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] SBS_TMO_RST = 32'h0000_0000;
  localparam logic [4:0] SBS_LAST_IDX = 5'h11;

  typedef enum {ST_IDLE, ST_WAIT_DATA, ST_READY, ST_SEND} sbs_state_type;
endpackage

// >>> src/sbs_frame_if.sv
// Purpose: carries the status record to the byte serializer
// Assumes: single clock domain
// Notes: load and next are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
interface sbs_frame_if;
  logic load;
  logic [127:0] record;
  logic next;
  logic [7:0] byte_q;
  modport src (output load, output record, output next, input byte_q);
  modport ser (input load, input record, input next, output byte_q);
endinterface // sbs_frame_if
`default_nettype wire

// >>> src/sbs_byte_ser.sv
// Purpose: holds the 18-byte block-read frame and hands it out a byte at a time
// Assumes: next never comes before load
// Notes: byte count and opcode are fixed, record follows low byte first
`timescale 1ns/1ps
`default_nettype none
module sbs_byte_ser
  import sbs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // frame carrier
  sbs_frame_if.ser frm
);
  logic [7:0] mem_q [SBS_FRAME_BYTES];
  logic [4:0] idx_q;
  logic [7:0] byte_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SBS_FRAME_BYTES; i++)
        mem_q[i] <= 8'h00;
    end
    else if (frm.load)
    begin
      mem_q[0] <= SBS_BYTE_COUNT;
      mem_q[1] <= SBS_OPC_LAST;
      for (int i = 0; i < SBS_REC_BYTES; i++)
        mem_q[i + 2] <= frm.record[i * 8 +: 8];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      idx_q <= 5'h00;
    else if (frm.load)
      idx_q <= 5'h00;
    else if (frm.next && idx_q != SBS_LAST_IDX + 5'h01)
      idx_q <= idx_q + 5'h01;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      byte_q <= 8'h00;
    else if (frm.next && idx_q <= SBS_LAST_IDX)
      byte_q <= mem_q[idx_q];
  end

  assign frm.byte_q = byte_q;
endmodule // sbs_byte_ser
`default_nettype wire

// >>> src/sbs_status_payload.sv
// Purpose: builds and sends the closing status response of a forwarded packet
// Assumes: packet fields are valid in the cycle frags_done is high
// Notes: APB slave, one wait-free access phase; timeout counted in ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module sbs_status_payload
  import sbs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // packet events
  input wire logic pkt_arrive,
  input wire logic frags_done,
  // packet fields
  input wire logic [15:0] pkt_len,
  input wire logic fcs_insert,
  input wire logic extra_vlan_present,
  input wire logic vlan_stripped,
  input wire logic direction,
  input wire logic lan_port,
  input wire logic [15:0] vlan_tag,
  // receive error bits
  input wire logic rx_data_error,
  input wire logic ipv4_checksum_error,
  input wire logic l4_checksum_error,
  input wire logic carrier_extension_error,
  input wire logic sequence_error,
  input wire logic symbol_error,
  input wire logic crc_align_error,
  // receive status bits
  input wire logic udp_fragment_checksum_valid,
  input wire logic ip_ident_valid,
  input wire logic fcs_check_valid,
  input wire logic ipv4_checksum_computed,
  input wire logic tcp_checksum_computed,
  input wire logic udp_checksum_computed,
  // manageability filter results
  input wire logic rmcp_port_a_match,
  input wire logic rmcp_port_b_match,
  input wire logic bcast_match,
  input wire logic neighbor_match,
  input wire logic arp_match,
  input wire logic vlan_filter_match,
  input wire logic unicast_match,
  input wire logic [2:0] unicast_index,
  input wire logic l4_port_match,
  input wire logic [6:0] l4_port_index,
  input wire logic flex_match,
  input wire logic [2:0] flex_index,
  input wire logic ip_addr_match,
  input wire logic [1:0] ip_addr_index,
  input wire logic ip_is_v6,
  input wire logic [7:0] decision_match,
  // smbus byte engine
  input wire logic sm_rd_start,
  input wire logic sm_byte_req,
  output logic [7:0] sm_byte_q,
  output logic sm_byte_valid_q,
  output logic sm_status_ready,
  output logic pkt_done_q,
  output logic pkt_dropped_q
);
  sbs_state_type state_q;
  logic [31:0] ctrl_q;
  logic [31:0] tmo_q;
  logic [31:0] tmo_cnt_q;
  logic [31:0] sent_q;
  logic [31:0] drop_q;
  logic [31:0] rdata_q;
  logic [127:0] rec_q;
  logic [127:0] rec_d;
  logic [39:0] mng;
  logic [4:0] out_cnt_q;
  logic tmo_hit;
  logic give;
  logic finish;
  logic take;
  logic hit;
  logic wr;
  sbs_frame_if frm ();

  sbs_byte_ser u_ser (
    .ref_clk(ref_clk),
    .rst(rst),
    .frm(frm)
  );

  // apb decode
  assign hit = (paddr == SBS_OFS_CTRL) || (paddr == SBS_OFS_TMO)
            || (paddr == SBS_OFS_STAT) || (paddr == SBS_OFS_SENT)
            || (paddr == SBS_OFS_DROP);
  assign wr = psel && penable && pwrite && hit;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_q;

  // read data caught in setup so it is steady through access
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == SBS_OFS_CTRL)
        rdata_q <= ctrl_q;
      else if (paddr == SBS_OFS_TMO)
        rdata_q <= tmo_q;
      else if (paddr == SBS_OFS_STAT)
        rdata_q <= {29'h0, state_q == ST_WAIT_DATA, state_q == ST_SEND,
                    state_q == ST_READY};
      else if (paddr == SBS_OFS_SENT)
        rdata_q <= sent_q;
      else if (paddr == SBS_OFS_DROP)
        rdata_q <= drop_q;
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= SBS_CTRL_RST;
    else if (wr && paddr == SBS_OFS_CTRL)
      ctrl_q <= {31'h0, pwdata[SBS_CTRL_MNG_EN]};
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tmo_q <= SBS_TMO_RST;
    else if (wr && paddr == SBS_OFS_TMO)
      tmo_q <= pwdata;
  end

  // manageability flags; only the flex index and the ipv6 flag are masked when their matches are clear
  always_comb
  begin
    mng = {decision_match,
           ip_is_v6 & (ip_addr_match | arp_match), ip_addr_match,
           ip_addr_index,
           flex_match, flex_index & {3{flex_match}},
           l4_port_match, l4_port_index,
           unicast_match, unicast_index,
           vlan_filter_match, 3'h0,
           3'h0, arp_match, neighbor_match, bcast_match,
           rmcp_port_b_match, rmcp_port_a_match};
  end

  // record assembly; untouched positions stay zero
  always_comb
  begin
    rec_d = '0;
    rec_d[SBS_REC_LEN_W-1:0] = pkt_len[SBS_REC_LEN_W-1:0];
    rec_d[SBS_REC_FCS_INS] = fcs_insert;
    rec_d[SBS_REC_XVLAN] = extra_vlan_present;
    rec_d[SBS_REC_VSTRIP] = vlan_stripped;
    rec_d[SBS_REC_DIR] = direction;
    rec_d[SBS_REC_LAN] = lan_port;
    rec_d[SBS_REC_VTAG_LSB +: 16] = vlan_tag;
    rec_d[SBS_REC_ERR_LSB +: 8] = {rx_data_error, ipv4_checksum_error,
                                   l4_checksum_error, carrier_extension_error,
                                   1'b0, sequence_error, symbol_error,
                                   crc_align_error};
    rec_d[SBS_REC_STAT_LSB +: 8] = {udp_fragment_checksum_valid,
                                    ip_ident_valid, fcs_check_valid, 1'b0,
                                    ipv4_checksum_computed,
                                    tcp_checksum_computed,
                                    udp_checksum_computed, 1'b0};
    // flags zeroed rather than left stale when reporting is off
    if (ctrl_q[SBS_CTRL_MNG_EN])
      rec_d[SBS_REC_MNG_LSB +: SBS_MNG_W] = mng;
  end

  // record is latched only once data fragments are done
  // a timeout in the same cycle wins, so no record is latched for a dropped packet
  assign take = frags_done && (state_q == ST_IDLE || (state_q == ST_WAIT_DATA && !tmo_hit));
  assign give = (state_q == ST_SEND) && sm_byte_req;
  assign finish = give && out_cnt_q == SBS_LAST_IDX;
  assign tmo_hit = (tmo_q != 32'h0) && (tmo_cnt_q >= tmo_q);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rec_q <= '0;
    else if (take)
      rec_q <= rec_d;
  end

  assign frm.load = take;
  assign frm.record = rec_d;
  assign frm.next = give;
  assign sm_byte_q = frm.byte_q;
  assign sm_status_ready = (state_q == ST_READY);

  // counted from arrival, so the wait for data also uses up the budget
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tmo_cnt_q <= 32'h0;
    else if (state_q == ST_IDLE)
      tmo_cnt_q <= 32'h0;
    else if (tmo_cnt_q != 32'hffff_ffff)
      tmo_cnt_q <= tmo_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (frags_done)
            state_q <= ST_READY;
          else if (pkt_arrive)
            state_q <= ST_WAIT_DATA;
        ST_WAIT_DATA:
          if (tmo_hit)
            state_q <= ST_IDLE;
          else if (frags_done)
            state_q <= ST_READY;
        ST_READY:
          if (tmo_hit)
            state_q <= ST_IDLE;
          else if (sm_rd_start)
            state_q <= ST_SEND;
        ST_SEND:
          // a finished read beats a timeout in the same cycle
          if (finish || tmo_hit)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      out_cnt_q <= 5'h00;
    else if (state_q != ST_SEND)
      out_cnt_q <= 5'h00;
    else if (give)
      out_cnt_q <= out_cnt_q + 5'h01;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sm_byte_valid_q <= 1'b0;
    else
      sm_byte_valid_q <= give;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pkt_done_q <= 1'b0;
      pkt_dropped_q <= 1'b0;
    end
    else
    begin
      pkt_done_q <= finish;
      pkt_dropped_q <= tmo_hit && !finish && state_q != ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sent_q <= 32'h0;
    else if (finish)
      sent_q <= sent_q + 32'h1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      drop_q <= 32'h0;
    else if (tmo_hit && !finish && state_q != ST_IDLE)
      drop_q <= drop_q + 32'h1;
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_read_begins;
    state_q == ST_READY && sm_rd_start && !tmo_hit;
  endsequence

  sequence s_first_req;
    state_q == ST_SEND && sm_byte_req && out_cnt_q == 5'h00;
  endsequence

  AST_COUNT_FIRST: assert property (
    s_read_begins ##1 s_first_req |=> sm_byte_valid_q && sm_byte_q == 8'h11)
    else $error("first byte is not the byte count");

  AST_OPCODE: assert property (
    sm_byte_valid_q && out_cnt_q == 5'h02 |-> sm_byte_q == 8'h50)
    else $error("second byte is not the last-fragment opcode");

  AST_REC_ORDER: assert property (
    sm_byte_valid_q && out_cnt_q > 5'h02
    |-> sm_byte_q == rec_q[(32'(out_cnt_q) - 3) * 8 +: 8])
    else $error("record byte out of order");

  AST_LEN_CAPTURE: assert property (
    take |=> rec_q[13:0] == $past(pkt_len[13:0]) && state_q == ST_READY)
    else $error("length not captured with the record");

  AST_RESERVED_ZERO: assert property (
    rec_q[24:14] == 11'h0 && rec_q[28:26] == 3'h0 && rec_q[33:31] == 3'h0
    && rec_q[47:36] == 12'h0 && rec_q[87:80] == 8'h0 && rec_q[67] == 1'b0
    && rec_q[76] == 1'b0 && rec_q[72] == 1'b0 && rec_q[98:93] == 6'h0)
    else $error("reserved record bit set");

  AST_FLEX_INDEX: assert property (
    !rec_q[SBS_REC_MNG_LSB + SBS_MNG_FLEX_MATCH] |-> rec_q[114:112] == 3'h0)
    else $error("flex index without flex match");

  AST_IP_VERSION: assert property (
    rec_q[SBS_REC_MNG_LSB + SBS_MNG_IP_V6]
    |-> rec_q[SBS_REC_MNG_LSB + SBS_MNG_IP_MATCH] || rec_q[SBS_REC_MNG_LSB + SBS_MNG_ARP])
    else $error("ip version flag without ip or arp match");

  AST_MNG_GATED: assert property (
    take && !ctrl_q[SBS_CTRL_MNG_EN] |=> rec_q[127:88] == 40'h0)
    else $error("match flags reported while disabled");

  AST_NO_EARLY_SEND: assert property (
    state_q == ST_WAIT_DATA |=> !sm_byte_valid_q [*2])
    else $error("status bytes before data fragments done");

  AST_TIMEOUT_DROP: assert property (
    tmo_hit && state_q != ST_IDLE && !finish
    |=> state_q == ST_IDLE && pkt_dropped_q && !pkt_done_q)
    else $error("timeout did not drop the packet");

  AST_DONE_AFTER_LAST: assert property (
    finish |=> sm_byte_valid_q && pkt_done_q && state_q == ST_IDLE)
    else $error("response not closed after eighteenth byte");
endmodule // sbs_status_payload
`default_nettype wire

// >>> tb/sbs_mc_model.sv
// Purpose: behavioural management controller reading the status response
// Assumes: one byte request at a time, gap cycles between bytes
// Notes: got and nb are read by the bench hierarchically
`timescale 1ns/1ps
`default_nettype none
module sbs_mc_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic [3:0] gap,
  output logic busy,
  // status response side
  input wire logic sm_status_ready,
  input wire logic [7:0] sm_byte_q,
  input wire logic sm_byte_valid_q,
  output logic sm_rd_start,
  output logic sm_byte_req
);
  logic [7:0] got [0:17];
  int nb;
  int w;
  initial
  begin
    sm_rd_start = 1'b0;
    sm_byte_req = 1'b0;
    busy = 1'b0;
    nb = 0;
    forever
    begin
      @(posedge ref_clk);
      // only starts once the closing record is held
      if (go === 1'b1 && sm_status_ready === 1'b1 && rst === 1'b0)
      begin
        busy <= 1'b1;
        nb = 0;
        sm_rd_start <= 1'b1;
        @(posedge ref_clk);
        sm_rd_start <= 1'b0;
        while (nb < 18)
        begin
          sm_byte_req <= 1'b1;
          @(posedge ref_clk);
          sm_byte_req <= 1'b0;
          w = 0;
          while (sm_byte_valid_q !== 1'b1 && w < 8) @(posedge ref_clk) w++;
          // no answer means the packet was withdrawn
          if (w == 8) break;
          got[nb] = sm_byte_q;
          nb++;
          repeat (gap) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // sbs_mc_model
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the status payload block
// Assumes: zero-wait apb, partner model reading the bytes
// Notes: packet fields packed into one random vector f
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbs_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pkt_arrive, frags_done, go, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, seed;
  logic [95:0] f;
  logic [3:0] gap;
  logic [31:0] prdata;
  logic [7:0] sm_byte_q;
  logic pready, pslverr, sm_rd_start, sm_byte_req, sm_byte_valid_q, sm_status_ready;
  logic pkt_done_q, pkt_dropped_q, busy;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n_done = 0;
  int n_drop = 0;

  sbs_status_payload i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_arrive(pkt_arrive), .frags_done(frags_done), .pkt_len(f[15:0]),
    .fcs_insert(f[16]), .extra_vlan_present(f[17]), .vlan_stripped(f[18]),
    .direction(f[19]), .lan_port(f[20]), .vlan_tag(f[36:21]), .rx_data_error(f[37]),
    .ipv4_checksum_error(f[38]), .l4_checksum_error(f[39]), .carrier_extension_error(f[40]),
    .sequence_error(f[41]), .symbol_error(f[42]), .crc_align_error(f[43]),
    .udp_fragment_checksum_valid(f[44]), .ip_ident_valid(f[45]), .fcs_check_valid(f[46]),
    .ipv4_checksum_computed(f[47]), .tcp_checksum_computed(f[48]),
    .udp_checksum_computed(f[49]), .rmcp_port_a_match(f[50]), .rmcp_port_b_match(f[51]),
    .bcast_match(f[52]), .neighbor_match(f[53]), .arp_match(f[54]),
    .vlan_filter_match(f[55]), .unicast_match(f[56]), .unicast_index(f[59:57]),
    .l4_port_match(f[60]), .l4_port_index(f[67:61]), .flex_match(f[68]),
    .flex_index(f[71:69]), .ip_addr_match(f[72]), .ip_addr_index(f[74:73]),
    .ip_is_v6(f[75]), .decision_match(f[83:76]), .sm_rd_start(sm_rd_start),
    .sm_byte_req(sm_byte_req), .sm_byte_q(sm_byte_q), .sm_byte_valid_q(sm_byte_valid_q),
    .sm_status_ready(sm_status_ready), .pkt_done_q(pkt_done_q), .pkt_dropped_q(pkt_dropped_q));

  sbs_mc_model i_mc (.ref_clk(ref_clk), .rst(rst), .go(go), .gap(gap), .busy(busy),
    .sm_status_ready(sm_status_ready), .sm_byte_q(sm_byte_q),
    .sm_byte_valid_q(sm_byte_valid_q), .sm_rd_start(sm_rd_start), .sm_byte_req(sm_byte_req));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // cycle budget well above the whole sequence
  always @(posedge ref_clk)
  begin
    cyc++;
    if (pkt_done_q === 1'b1) n_done++;
    if (pkt_dropped_q === 1'b1) n_drop++;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [95:0] rnd();
    return {$random(seed), $random(seed), $random(seed)};
  endfunction

  function automatic logic [127:0] exp_rec(input logic [95:0] v, input logic en);
    logic [127:0] r;
    logic [39:0] m;
    r = '0;
    m = '0;
    r[13:0] = v[13:0];
    r[25] = v[16];
    r[30:29] = v[18:17];
    r[35:34] = v[20:19];
    r[63:48] = v[36:21];
    r[71:64] = {v[37], v[38], v[39], v[40], 1'b0, v[41], v[42], v[43]};
    r[79:72] = {v[44], v[45], v[46], 1'b0, v[47], v[48], v[49], 1'b0};
    m[4:0] = v[54:50];
    m[11] = v[55];
    m[15:12] = {v[56], v[59:57]};
    m[23:16] = {v[60], v[67:61]};
    m[27:24] = {v[68], v[68] ? v[71:69] : 3'h0};
    m[30:28] = {v[72], v[74:73]};
    m[31] = v[75] & (v[72] | v[54]);
    m[39:32] = v[83:76];
    if (en) r[127:88] = m;
    return r;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_pkt(input logic [95:0] v, input logic [3:0] g, input logic en,
                         input logic ok);
    int n;
    int d0;
    logic [127:0] e;
    n = 0;
    d0 = n_done;
    e = exp_rec(v, en);
    // top bit of the vector decides whether an arrival precedes the data
    @(posedge ref_clk);
    pkt_arrive <= v[95];
    @(posedge ref_clk);
    pkt_arrive <= 1'b0;
    f <= v;
    gap <= g;
    frags_done <= 1'b1;
    go <= 1'b1;
    @(posedge ref_clk);
    frags_done <= 1'b0;
    while (busy !== 1'b1 && n < 20) @(posedge ref_clk) n++;
    while (busy !== 1'b0 && n < 400) @(posedge ref_clk) n++;
    go <= 1'b0;
    repeat (2) @(posedge ref_clk);
    if (ok)
    begin
      chk(i_mc.nb, 18);
      chk(i_mc.got[0], SBS_BYTE_COUNT);
      chk(i_mc.got[1], SBS_OPC_LAST);
      for (int i = 0; i < 16; i++) chk(i_mc.got[i + 2], e[i * 8 +: 8]);
      chk(n_done - d0, 1);
    end
    else
    begin
      chk(i_mc.nb < 18, 1'b1);
      chk(n_done - d0, 0);
    end
  endtask

  initial
  begin
    int n;
    seed = 32'h325dfc85;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pkt_arrive = 1'b0;
    frags_done = 1'b0;
    f = '0;
    gap = 4'h0;
    go = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, SBS_OFS_CTRL, 32'h0);
    chk(rd, SBS_CTRL_RST);
    apb(1'b0, SBS_OFS_TMO, 32'h0);
    chk(rd, SBS_TMO_RST);
    // unmapped place: refused, reads zero
    apb(1'b0, 12'h014, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    // corners: all clear, all set, ipv6 flag and flex index without matches
    run_pkt('0, 4'h0, 1'b1, 1'b1);
    run_pkt('1, 4'h1, 1'b1, 1'b1);
    run_pkt((96'h1 << 75) | (96'h7 << 69), 4'h0, 1'b1, 1'b1);
    for (int i = 0; i < 12; i++) run_pkt(rnd(), 4'(i % 3), 1'b1, 1'b1);
    apb(1'b1, SBS_OFS_CTRL, 32'h0);
    apb(1'b0, SBS_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) run_pkt(rnd(), 4'h0, 1'b0, 1'b1);
    apb(1'b1, SBS_OFS_CTRL, 32'h1);
    apb(1'b0, SBS_OFS_SENT, 32'h0);
    chk(rd, 32'd19);
    // timeout while still waiting for the data fragments
    apb(1'b1, SBS_OFS_TMO, 32'd40);
    @(posedge ref_clk);
    pkt_arrive <= 1'b1;
    @(posedge ref_clk);
    pkt_arrive <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(sm_status_ready, 1'b0);
    apb(1'b0, SBS_OFS_STAT, 32'h0);
    chk(rd, 32'h4);
    n = 0;
    while (n_drop < 1 && n < 100) @(posedge ref_clk) n++;
    chk(n_drop, 1);
    chk(sm_status_ready, 1'b0);
    // slow reader loses the packet in mid-send
    run_pkt(rnd(), 4'h4, 1'b1, 1'b0);
    chk(n_drop, 2);
    apb(1'b0, SBS_OFS_DROP, 32'h0);
    chk(rd, 32'd2);
    apb(1'b0, SBS_OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
